// [hw/bldc_commutation_protection_ctrl.sv]
// Commutation, PWM, braking and protection logic of the motor pre-driver.
`timescale 1ns/1ns
`default_nettype none
`include "bldc_ctrl_cfg.svh"
// Overview of operation
// - All three Hall inputs high is an error; in run mode every gate output goes off.
// - Halt mode input low with regen stop enable high gives normal Hall-driven commutation.
// - Halt mode input high drives all three low-side gates on.
// - In halt mode, regen stop enable high holds all low sides on; low gives PWM braking.
// - Undervoltage comparator result appears on its own output pin.
// - Unconnected undervoltage sense always reads as undervoltage.
// - No Hall edge within the stall timeout switches high-side outputs off.
// - Stall timeout is a configurable cycle count, 33 s per microfarad.
// - Stall timer also holds logic in start-up reset until first timeout.
// - Stall shutdown clears only at command of 1.1 V or less, or power cycle.
// - Spacing select high decodes 120 degree sensors, low decodes 60 degree.
// - Direction change while turning applies shoot-through prevention.
// - Below full duty the low-side FET turns on every PWM cycle.
// - At full duty bootstrap recharge happens only at commutation.
// - Reference is (cmd-1.27)*0.03 below 3 V, (cmd-3)*0.095+0.0519 up to 3.6 V.
// - Above 3.6 V command the reference saturates at 0.105 V; the 16-bit port clips it at 16'hFFFF from 3.144 V.
// - PWM period is a configurable count from the oscillator law.
// - Regen stop enable low gives low-side PWM braking set by brake level.
// - Two half-bridges active per segment; reverse reverses phase order.
// - Below full duty, sensed current above reference ends the PWM on-time in that cycle.
// - Off-time turns low side on with deadtime between gate turn-ons.
module bldc_commutation_protection_ctrl #(
  parameter int PWM_PERIOD = `PWM_PERIOD_CYC,
  parameter int STALL_CYCLES = `STALL_CYC,
  parameter int DEADTIME = `DEADTIME_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic hall_position_a,
  input wire logic hall_position_b,
  input wire logic hall_position_c,
  input wire logic spacing_120_sel,
  input wire logic reverse_dir,
  input wire logic halt_mode_input,
  input wire logic regen_stop_enable_n,
  input wire logic [15:0] stopping_duty_level,
  input wire logic [15:0] torque_command_voltage,
  input wire logic [15:0] current_sense_input,
  input wire logic undervoltage_sense_in,
  input wire logic undervoltage_sense_open,
  output logic undervoltage_compare_out,
  output logic [15:0] current_reference_level,
  output logic stall_latched,
  output logic startup_reset_active,
  output logic phase_a_high_gate,
  output logic phase_b_high_gate,
  output logic phase_c_high_gate,
  output logic phase_a_low_gate,
  output logic phase_b_low_gate,
  output logic phase_c_low_gate
);
  localparam int PW = $clog2(PWM_PERIOD + 1);
  localparam int SW = $clog2(STALL_CYCLES + 1);
  localparam int DW = $clog2(DEADTIME + 2);
  localparam logic [PW-1:0] PERIOD_LAST = PW'(PWM_PERIOD - 1);
  localparam logic [SW-1:0] STALL_LAST = SW'(STALL_CYCLES - 1);
  localparam logic [DW-1:0] DEAD_CNT = DW'(DEADTIME);

  logic [2:0] hall;
  logic hall_valid;
  logic [2:0] high_sel;
  logic [2:0] low_sel;
  logic [15:0] ref_uv;
  logic uv_flag;
  logic run_enable;
  logic full_duty;

  logic [PW-1:0] pwm_cnt_r, pwm_cnt_nxt;
  logic [PW-1:0] duty_r, duty_nxt;
  logic [PW-1:0] brake_duty;
  logic on_phase_r, on_phase_nxt;
  logic [DW-1:0] dead_r, dead_nxt;
  logic [2:0] hall_r, hall_nxt;
  logic dir_r, dir_nxt;
  logic [SW-1:0] stall_cnt_r, stall_cnt_nxt;
  bldc_ctrl_pkg::stall_state_t stall_r, stall_nxt;
  bldc_ctrl_pkg::drive_mode_t mode;
  logic [5:0] gate_r, gate_nxt;

  // Scale a millivolt-like code linearly onto the PWM period.
  function automatic logic [PW-1:0] scale_duty(input logic [15:0] num, input logic [15:0] den);
    logic [47:0] p;
    p = {32'h0, num} * 48'(PWM_PERIOD);
    return (den == 16'h0) ? '0 : PW'(p / {32'h0, den});
  endfunction

  assign hall = {hall_position_c, hall_position_b, hall_position_a};

  hall_step_decode u_decode (
    .hall(hall),
    .spacing_120(spacing_120_sel),
    .reverse(reverse_dir),
    .valid(hall_valid),
    .high_sel(high_sel),
    .low_sel(low_sel)
  );

  current_ref_curve u_curve (
    .cmd_mv(torque_command_voltage),
    .ref_uv(ref_uv)
  );

  // A floating sense pin reads as undervoltage regardless of the comparator.
  assign uv_flag = undervoltage_sense_open | ~undervoltage_sense_in;
  assign undervoltage_compare_out = uv_flag;
  assign current_reference_level = ref_uv;

  // Duty from the reference; the clipped 16-bit full-scale reference maps to the full period.
  assign full_duty = (duty_r == PERIOD_LAST) || (duty_r > PERIOD_LAST);
  // Brake duty: 1.1 V gives 100 %, 3.0 V gives 0 %.
  always_comb begin
    if (stopping_duty_level <= `BRAKE_FULL_MV) begin
      brake_duty = PW'(PWM_PERIOD);
    end else if (stopping_duty_level >= `BRAKE_ZERO_MV) begin
      brake_duty = '0;
    end else begin
      brake_duty = scale_duty(`BRAKE_ZERO_MV - stopping_duty_level,
                              `BRAKE_ZERO_MV - `BRAKE_FULL_MV);
    end
  end

  always_comb begin
    if (uv_flag) begin
      mode = bldc_ctrl_pkg::MODE_OFF;
    end else if (!regen_stop_enable_n) begin
      mode = bldc_ctrl_pkg::MODE_EBRAKE;
    end else if (halt_mode_input) begin
      mode = bldc_ctrl_pkg::MODE_SHORT;
    end else begin
      mode = bldc_ctrl_pkg::MODE_RUN;
    end
  end

  assign run_enable = (stall_r == bldc_ctrl_pkg::ST_DRIVE);

  // PWM timebase, duty, and stall supervision.
  always_comb begin
    pwm_cnt_nxt = (pwm_cnt_r >= PERIOD_LAST) ? '0 : pwm_cnt_r + 1'b1;
    duty_nxt = duty_r;
    if (pwm_cnt_r >= PERIOD_LAST) begin
      // The reference port clips at 16'hFFFF, so scale against that code, not 0.105 V.
      duty_nxt = scale_duty(ref_uv, 16'hFFFF);
      if (ref_uv == 16'hFFFF) begin
        duty_nxt = PERIOD_LAST;
      end
    end
    on_phase_nxt = on_phase_r;
    if (pwm_cnt_r >= PERIOD_LAST) begin
      on_phase_nxt = 1'b1;
    end else if (!full_duty && (pwm_cnt_r >= duty_r)) begin
      on_phase_nxt = 1'b0;
    end
    if ({16'h0, current_sense_input} > {16'h0, ref_uv} && !full_duty) begin
      on_phase_nxt = 1'b0;
    end
    hall_nxt = hall;
    dir_nxt = reverse_dir;
    stall_nxt = stall_r;
    stall_cnt_nxt = stall_cnt_r;
    case (stall_r)
      bldc_ctrl_pkg::ST_STARTUP: begin
        stall_cnt_nxt = stall_cnt_r + 1'b1;
        if (stall_cnt_r >= STALL_LAST) begin
          stall_nxt = bldc_ctrl_pkg::ST_DRIVE;
          stall_cnt_nxt = '0;
        end
      end
      bldc_ctrl_pkg::ST_DRIVE: begin
        if (hall != hall_r || mode != bldc_ctrl_pkg::MODE_RUN) begin
          stall_cnt_nxt = '0;
        end else if (stall_cnt_r >= STALL_LAST) begin
          stall_nxt = bldc_ctrl_pkg::ST_LOCKED;
        end else begin
          stall_cnt_nxt = stall_cnt_r + 1'b1;
        end
      end
      bldc_ctrl_pkg::ST_LOCKED: begin
        if (torque_command_voltage <= `CMD_RELEASE_MV) begin
          stall_nxt = bldc_ctrl_pkg::ST_DRIVE;
          stall_cnt_nxt = '0;
        end
      end
      default: begin
        stall_nxt = bldc_ctrl_pkg::ST_STARTUP;
        stall_cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwm_cnt_r <= '0;
      duty_r <= '0;
      on_phase_r <= 1'b0;
      hall_r <= 3'h0;
      dir_r <= 1'b0;
      stall_cnt_r <= '0;
      stall_r <= bldc_ctrl_pkg::ST_STARTUP;
    end else begin
      pwm_cnt_r <= pwm_cnt_nxt;
      duty_r <= duty_nxt;
      on_phase_r <= on_phase_nxt;
      hall_r <= hall_nxt;
      dir_r <= dir_nxt;
      stall_cnt_r <= stall_cnt_nxt;
      stall_r <= stall_nxt;
    end
  end

  // Gate outputs; gate_r is {low c,b,a, high c,b,a}.
  always_comb begin
    gate_nxt = 6'h00;
    dead_nxt = (dead_r != '0) ? dead_r - 1'b1 : '0;
    // Any commutation or direction change starts the deadtime; below full duty both sides are blanked.
    if (hall != hall_r || reverse_dir != dir_r) begin
      dead_nxt = DEAD_CNT;
    end else if (on_phase_nxt != on_phase_r) begin
      dead_nxt = DEAD_CNT;
    end
    case (mode)
      bldc_ctrl_pkg::MODE_OFF: gate_nxt = 6'h00;
      bldc_ctrl_pkg::MODE_SHORT: gate_nxt = 6'h38;
      bldc_ctrl_pkg::MODE_EBRAKE: begin
        gate_nxt = (pwm_cnt_r < brake_duty) ? 6'h38 : 6'h00;
      end
      bldc_ctrl_pkg::MODE_RUN: begin
        if (!hall_valid || !run_enable) begin
          gate_nxt = 6'h00;
        end else if (dead_nxt != '0) begin
          // Full duty keeps the low side on across the commutation gap.
          gate_nxt = full_duty ? {low_sel, 3'b000} : 6'h00;
        end else if (on_phase_r) begin
          gate_nxt = {low_sel, high_sel};
        end else begin
          gate_nxt = {low_sel | high_sel, 3'b000};
        end
      end
      default: gate_nxt = 6'h00;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gate_r <= 6'h00;
      dead_r <= '0;
    end else begin
      gate_r <= gate_nxt;
      dead_r <= dead_nxt;
    end
  end

  assign phase_a_high_gate = gate_r[0];
  assign phase_b_high_gate = gate_r[1];
  assign phase_c_high_gate = gate_r[2];
  assign phase_a_low_gate = gate_r[3];
  assign phase_b_low_gate = gate_r[4];
  assign phase_c_low_gate = gate_r[5];
  assign stall_latched = (stall_r == bldc_ctrl_pkg::ST_LOCKED);
  assign startup_reset_active = (stall_r == bldc_ctrl_pkg::ST_STARTUP);
endmodule // bldc_commutation_protection_ctrl
`default_nettype wire

// [hw/bldc_ctrl_cfg.svh]
// Constants and timing counts for the brushless commutation controller.
`ifndef BLDC_CTRL_CFG_SVH
`define BLDC_CTRL_CFG_SVH
`define CLK_HZ 50000000
// Oscillator law: f = 1 / (K * C); K in ohms, capacitance in picofarads.
`define PWM_OSC_K 50000
`define PWM_CAP_PF 1000
// Divided in two steps so the product stays inside a 32-bit signed integer.
`define PWM_PERIOD_CYC ((`CLK_HZ / 1000000) * `PWM_OSC_K / 1000 * `PWM_CAP_PF / 1000)
// Stall time = 33 s per microfarad; the cap is given in nanofarads.
`define STALL_S_PER_UF 33
`define STALL_CAP_NF 10
`define STALL_CYC (`CLK_HZ / 1000 * `STALL_S_PER_UF * `STALL_CAP_NF)
`define DEADTIME_NS 200
`define DEADTIME_CYC ((`DEADTIME_NS * (`CLK_HZ / 1000000) + 999) / 1000)
// Analog levels as millivolt codes; the reference levels are microvolt codes.
`define CMD_OFFSET_MV 16'h04F6
`define CMD_KNEE_MV 16'h0BB8
`define CMD_SAT_MV 16'h0E10
`define CMD_RELEASE_MV 16'h044C
`define REF_KNEE_UV 32'h0000CABC
`define REF_SAT_UV 32'h00019A28
`define LOW_GAIN_PPK 32'h0000001E
`define HIGH_GAIN_PPK 32'h0000005F
`define BRAKE_FULL_MV 16'h044C
`define BRAKE_ZERO_MV 16'h0BB8
`endif

// [hw/bldc_ctrl_pkg.sv]
// Types shared by the brushless commutation controller.
package bldc_ctrl_pkg;
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_SHORT = 2'b01,
    MODE_EBRAKE = 2'b10,
    MODE_OFF = 2'b11
  } drive_mode_t;
  typedef enum logic [1:0] {
    ST_STARTUP = 2'b00,
    ST_DRIVE = 2'b01,
    ST_LOCKED = 2'b10
  } stall_state_t;
endpackage

// [hw/current_ref_curve.sv]
// Piecewise current reference curve from the torque command voltage.
`timescale 1ns/1ns
`default_nettype none
`include "bldc_ctrl_cfg.svh"
module current_ref_curve (
  input wire logic [15:0] cmd_mv,
  output logic [15:0] ref_uv
);
  logic [31:0] ref_w;
  always_comb begin
    ref_w = 32'h0;
    if (cmd_mv <= `CMD_OFFSET_MV) begin
      ref_w = 32'h0;
    end else if (cmd_mv < `CMD_KNEE_MV) begin
      ref_w = {16'h0, cmd_mv - `CMD_OFFSET_MV} * `LOW_GAIN_PPK;
    end else if (cmd_mv <= `CMD_SAT_MV) begin
      ref_w = {16'h0, cmd_mv - `CMD_KNEE_MV} * `HIGH_GAIN_PPK + `REF_KNEE_UV;
    end else begin
      ref_w = `REF_SAT_UV;
    end
  end
  // Microvolt result; 0.105 V fits in 17 bits, so saturate into 16.
  assign ref_uv = (ref_w > 32'h0000FFFF) ? 16'hFFFF : ref_w[15:0];
endmodule // current_ref_curve
`default_nettype wire

// [hw/hall_step_decode.sv]
// Hall position decoder to a six-step commutation pattern.
`timescale 1ns/1ns
`default_nettype none
module hall_step_decode (
  input wire logic [2:0] hall,
  input wire logic spacing_120,
  input wire logic reverse,
  output logic valid,
  output logic [2:0] high_sel,
  output logic [2:0] low_sel
);
  logic [2:0] step;
  logic [2:0] code;
  always_comb begin
    step = 3'h0;
    valid = 1'b1;
    // 60 degree sensors: invert the middle sensor to reuse the 120 degree table.
    code = spacing_120 ? hall : {hall[2], ~hall[1], hall[0]};
    case (code)
      3'h1: step = 3'h0;
      3'h3: step = 3'h1;
      3'h2: step = 3'h2;
      3'h6: step = 3'h3;
      3'h4: step = 3'h4;
      3'h5: step = 3'h5;
      default: valid = 1'b0;
    endcase
    if (hall == 3'h7) begin
      valid = 1'b0;
    end
    if (reverse) begin
      step = (step >= 3'h3) ? step - 3'h3 : step + 3'h3;
    end
    high_sel = 3'h0;
    low_sel = 3'h0;
    case (step)
      3'h0: begin high_sel = 3'b001; low_sel = 3'b010; end
      3'h1: begin high_sel = 3'b001; low_sel = 3'b100; end
      3'h2: begin high_sel = 3'b010; low_sel = 3'b100; end
      3'h3: begin high_sel = 3'b010; low_sel = 3'b001; end
      3'h4: begin high_sel = 3'b100; low_sel = 3'b001; end
      3'h5: begin high_sel = 3'b100; low_sel = 3'b010; end
      default: begin high_sel = 3'b000; low_sel = 3'b000; end
    endcase
    if (!valid) begin
      high_sel = 3'b000;
      low_sel = 3'b000;
    end
  end
endmodule // hall_step_decode
`default_nettype wire

// [tb/bldc_commutation_protection_ctrl_tb.sv]
// Self-checking bench for the commutation and protection controller.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("Error %s expected %0h seen %0h", n, e, g); end end
module bldc_commutation_protection_ctrl_tb;
  localparam int PER = 20;
  localparam int STALL = 50;
  localparam int DT = 2;
  logic clock, arst_n, hall_position_a, hall_position_b, hall_position_c, spacing_120_sel;
  logic reverse_dir, halt_mode_input, regen_stop_enable_n, undervoltage_sense_in;
  logic undervoltage_sense_open, undervoltage_compare_out, stall_latched, startup_reset_active;
  logic phase_a_high_gate, phase_b_high_gate, phase_c_high_gate, fault_all_high, supply_low;
  logic phase_a_low_gate, phase_b_low_gate, phase_c_low_gate;
  logic [15:0] stopping_duty_level, torque_command_voltage, current_sense_input;
  logic [15:0] current_reference_level;
  logic [2:0] rotor_step;
  logic [5:0] gates;
  int bad_count = 0;
  int comparisons = 0;
  assign gates = {phase_c_high_gate, phase_b_high_gate, phase_a_high_gate,
    phase_c_low_gate, phase_b_low_gate, phase_a_low_gate};
  bldc_commutation_protection_ctrl #(.PWM_PERIOD(PER), .STALL_CYCLES(STALL), .DEADTIME(DT)) uut (.*);
  hall_sensor_model partner (.*);
  always #10 clock = ~clock;
  task automatic stop_test;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Keeps the rotor turning so the stall timer never expires mid-scenario.
  task automatic spin(input int n);
    repeat (n) begin
      rotor_step = (rotor_step == 3'h5) ? 3'h0 : rotor_step + 3'h1;
      cyc(DT + 4);
    end
  endtask
  task automatic rearm(input logic [15:0] cmd);
    torque_command_voltage = 16'h03E8;
    cyc(3);
    torque_command_voltage = cmd;
    spin(8);
  endtask
  task automatic t_startup;
    cyc(STALL - 4);
    `CHK("startup", 1'b1, startup_reset_active)
    `CHK("startup highs", 3'h0, gates[5:3])
    cyc(8);
    `CHK("startup end", 1'b0, startup_reset_active)
    $display("startup test done");
  endtask
  task automatic t_ref;
    logic [15:0] cmd [5] = '{16'h07D0, 16'h0AF0, 16'h0BB8, 16'h0C1C, 16'h0ED8};
    logic [15:0] want [5] = '{16'h558C, 16'hB34C, 16'hCABC, 16'hEFD8, 16'hFFFF};
    for (int i = 0; i < 5; i++) begin
      torque_command_voltage = cmd[i];
      cyc(1);
      `CHK("reference", want[i], current_reference_level)
    end
    $display("reference test done");
  endtask
  task automatic t_run;
    logic [5:0] fw [6];
    rearm(16'h0ED8);
    for (int k = 0; k < 6; k++) begin
      rotor_step = 3'(k);
      cyc(DT + 4);
      fw[k] = gates;
      `CHK("one high", 1'b1, $onehot(fw[k][5:3]))
      `CHK("one low", 1'b1, $onehot(fw[k][2:0]))
      `CHK("phase split", 3'h0, fw[k][5:3] & fw[k][2:0])
      cyc(1);
      `CHK("full duty hold", fw[k], gates)
    end
    for (int k = 0; k < 6; k++) begin
      `CHK("six step", {fw[k][2:0], fw[k][5:3]}, fw[(k + 3) % 6])
    end
    reverse_dir = 1'b1;
    for (int k = 0; k < 6; k++) begin
      rotor_step = 3'(k);
      cyc(DT + 4);
      `CHK("reverse", fw[(k + 3) % 6], gates)
    end
    reverse_dir = 1'b0;
    spacing_120_sel = 1'b0;
    for (int k = 0; k < 6; k++) begin
      if (k % 3 != 2) begin
        rotor_step = 3'(k);
        cyc(DT + 4);
        `CHK("sixty degree", fw[k], gates)
      end
    end
    spacing_120_sel = 1'b1;
    $display("run test done");
  endtask
  task automatic t_pwm;
    logic [2:0] hs = 3'h0;
    logic [2:0] ls = 3'h0;
    int on_n = 0;
    int lim_n = 0;
    rearm(16'h07D0);
    repeat (2 * PER) begin
      cyc(1);
      hs |= gates[5:3];
      ls |= gates[2:0];
      on_n += (gates[5:3] != 3'h0);
    end
    `CHK("pwm on phase", 1'b1, hs != 3'h0)
    `CHK("bootstrap refresh", 1'b1, (hs & ls) != 3'h0)
    `CHK("below full duty", 1'b1, on_n < 2 * PER)
    current_sense_input = 16'hFFFF;
    spin(1);
    repeat (2 * PER) begin
      cyc(1);
      lim_n += (gates[5:3] != 3'h0);
    end
    `CHK("current limit", 1'b1, lim_n < on_n)
    current_sense_input = 16'h0000;
    $display("pwm test done");
  endtask
  task automatic t_hall_err;
    rearm(16'h0ED8);
    fault_all_high = 1'b1;
    cyc(3);
    `CHK("all hall high", 6'h00, gates)
    fault_all_high = 1'b0;
    $display("hall error test done");
  endtask
  task automatic t_brake;
    int n = 0;
    halt_mode_input = 1'b1;
    cyc(3);
    `CHK("short brake", 6'h07, gates)
    regen_stop_enable_n = 1'b0;
    stopping_duty_level = 16'h03E8;
    cyc(2 * PER + 2);
    `CHK("brake full", 6'h07, gates)
    stopping_duty_level = 16'h0BB8;
    cyc(2 * PER + 2);
    `CHK("brake none", 6'h00, gates)
    stopping_duty_level = 16'h07D0;
    cyc(2 * PER);
    repeat (2 * PER) begin
      cyc(1);
      n += (gates[2:0] != 3'h0);
    end
    `CHK("brake partial", 1'b1, n > 0 && n < 2 * PER)
    regen_stop_enable_n = 1'b1;
    $display("brake test done");
  endtask
  task automatic t_uv;
    for (int m = 0; m < 3; m++) begin
      undervoltage_sense_open = (m == 0);
      supply_low = (m == 1);
      cyc(2);
      `CHK("uv flag", m < 2, undervoltage_compare_out)
      `CHK("uv gates", (m < 2) ? 6'h00 : 6'h07, gates)
    end
    halt_mode_input = 1'b0;
    $display("undervoltage test done");
  endtask
  task automatic t_stall;
    rearm(16'h0ED8);
    cyc(STALL - 8);
    `CHK("stall early", 1'b0, stall_latched)
    cyc(12);
    `CHK("stall", 1'b1, stall_latched)
    `CHK("stall highs", 3'h0, gates[5:3])
    spin(2);
    `CHK("stall held", 1'b1, stall_latched)
    torque_command_voltage = 16'h044C;
    cyc(3);
    `CHK("stall release", 1'b0, stall_latched)
    $display("stall test done");
  endtask
  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    rotor_step = 3'h0;
    fault_all_high = 1'b0;
    supply_low = 1'b0;
    spacing_120_sel = 1'b1;
    reverse_dir = 1'b0;
    halt_mode_input = 1'b0;
    regen_stop_enable_n = 1'b1;
    stopping_duty_level = 16'h0BB8;
    torque_command_voltage = 16'h0ED8;
    current_sense_input = 16'h0000;
    undervoltage_sense_open = 1'b0;
    cyc(12);
    arst_n = 1'b1;
    t_startup();
    t_ref();
    t_run();
    t_pwm();
    t_hall_err();
    t_brake();
    t_uv();
    t_stall();
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    stop_test();
  end
endmodule // bldc_commutation_protection_ctrl_tb
`default_nettype wire

// [tb/bldc_ctrl_properties.sv]
// Concurrent checks on the ports of the commutation controller.
`timescale 1ns/1ns
`default_nettype none
module bldc_ctrl_properties #(
  parameter int STALL_CYCLES = 50
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic hall_position_a,
  input wire logic hall_position_b,
  input wire logic hall_position_c,
  input wire logic halt_mode_input,
  input wire logic regen_stop_enable_n,
  input wire logic [15:0] torque_command_voltage,
  input wire logic undervoltage_sense_in,
  input wire logic undervoltage_sense_open,
  input wire logic undervoltage_compare_out,
  input wire logic [15:0] current_reference_level,
  input wire logic stall_latched,
  input wire logic startup_reset_active,
  input wire logic phase_a_high_gate,
  input wire logic phase_b_high_gate,
  input wire logic phase_c_high_gate,
  input wire logic phase_a_low_gate,
  input wire logic phase_b_low_gate,
  input wire logic phase_c_low_gate
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic [2:0] hi;
  logic [2:0] lo;
  logic run_mode;
  int unsigned boot_cnt_r;
  int unsigned boot_cnt_nxt;
  assign hi = {phase_c_high_gate, phase_b_high_gate, phase_a_high_gate};
  assign lo = {phase_c_low_gate, phase_b_low_gate, phase_a_low_gate};
  assign run_mode = !halt_mode_input && regen_stop_enable_n && !undervoltage_compare_out;
  // Counts the start-up hold so its length can be checked without a long repetition.
  always_comb begin
    boot_cnt_nxt = startup_reset_active ? boot_cnt_r + 1 : boot_cnt_r;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      boot_cnt_r <= 0;
    else
      boot_cnt_r <= boot_cnt_nxt;
  end
  uv_output_a: assert property (undervoltage_compare_out ==
    (undervoltage_sense_open || !undervoltage_sense_in)) else $error("uv flag wrong");
  uv_gates_off_a: assert property (undervoltage_compare_out |=> hi == 3'h0 && lo == 3'h0)
    else $error("gates on in undervoltage");
  hall_error_off_a: assert property (run_mode && hall_position_a && hall_position_b
    && hall_position_c |=> hi == 3'h0 && lo == 3'h0) else $error("gates on with bad hall");
  short_brake_a: assert property (halt_mode_input && regen_stop_enable_n
    && !undervoltage_compare_out |=> lo == 3'h7 && hi == 3'h0) else $error("short brake wrong");
  ebrake_high_a: assert property (!regen_stop_enable_n |=> hi == 3'h0)
    else $error("high gate on in e-brake");
  boot_hold_a: assert property (startup_reset_active && run_mode |=> hi == 3'h0)
    else $error("drive during start-up");
  boot_length_a: assert property ($fell(startup_reset_active) |->
    boot_cnt_r inside {[STALL_CYCLES - 1:STALL_CYCLES + 1]}) else $error("start-up length wrong");
  stall_off_a: assert property (stall_latched && $past(stall_latched) |-> hi == 3'h0)
    else $error("high gate on while stalled");
  stall_hold_a: assert property (stall_latched && torque_command_voltage > 16'h044C
    |=> stall_latched) else $error("stall cleared early");
  stall_release_a: assert property (stall_latched && torque_command_voltage <= 16'h044C
    |-> ##[1:2] !stall_latched) else $error("stall not released");
  no_shoot_a: assert property ((hi & lo) == 3'h0) else $error("shoot-through");
  single_high_a: assert property ($countones(hi) <= 1) else $error("two high gates");
  ref_sat_a: assert property (torque_command_voltage > 16'h0E10
    |-> current_reference_level == 16'hFFFF) else $error("reference not saturated");
  cover property (stall_latched);
  cover property ($fell(startup_reset_active));
  cover property (lo == 3'h7);
endmodule // bldc_ctrl_properties
bind bldc_commutation_protection_ctrl bldc_ctrl_properties #(.STALL_CYCLES(STALL_CYCLES)) chk (.*);
`default_nettype wire

// [tb/hall_sensor_model.sv]
// Hall sensor set and supply sense network that face the controller.
`timescale 1ns/1ns
`default_nettype none
module hall_sensor_model (
  input wire logic [2:0] rotor_step,
  input wire logic spacing_120_sel,
  input wire logic fault_all_high,
  input wire logic supply_low,
  output logic hall_position_a,
  output logic hall_position_b,
  output logic hall_position_c,
  output logic undervoltage_sense_in
);
  logic [2:0] code;
  always_comb begin
    case (rotor_step)
      3'h0: code = 3'h1;
      3'h1: code = 3'h3;
      3'h2: code = 3'h2;
      3'h3: code = 3'h6;
      3'h4: code = 3'h4;
      default: code = 3'h5;
    endcase
    // Sensors mounted at 60 degrees see the middle sensor flipped.
    if (!spacing_120_sel)
      code[1] = ~code[1];
    if (fault_all_high)
      code = 3'h7;
  end
  assign {hall_position_c, hall_position_b, hall_position_a} = code;
  // The board keeps the sense level above the reference unless a sag is modelled.
  assign undervoltage_sense_in = !supply_low;
endmodule // hall_sensor_model
`default_nettype wire
